// file: common/supervision_timer_pkg.sv
// Constants, register map and field layout of the supervision timer
// Notes on behaviour
// - The supervision counter advances on low-frequency oscillator edges, never on the system clock alone.
// - When the counter overflows, a system reset is asserted that returns the whole controller to reset.
// - After any reset the timer is enabled and counting with the longest timeout interval selected.
// - Software may disable the timer or lock it in the enabled state.
// - Once locked, every attempt to disable the timer is ignored until the next system reset.
// - While locked, no control setting change, the interval included, is accepted until a system reset; the interrupt mask stays writable.
// - A reset caused by overflow never drives or changes the external reset pin.
`default_nettype none
package supervision_timer_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 12'h00C;
  localparam logic [ADDR_W-1:0] COUNT_OFFSET = 12'h010;
  // Control fields
  localparam int EN_BIT = 0;
  localparam int LOCK_BIT = 1;
  localparam int RESTART_BIT = 2;
  localparam int IV_LSB = 4;
  localparam int IV_W = 3;
  localparam logic [IV_W-1:0] IV_MAX = 3'h7;
  localparam logic EN_RESET = 1'h1;
  localparam logic LOCK_RESET = 1'h0;
  // Status fields
  localparam int ST_EN_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_FIRED_BIT = 2;
  // Interrupt fields
  localparam int IRQ_W = 3;
  localparam int IRQ_HALF_BIT = 0;
  localparam int IRQ_RESTART_BIT = 1;
  localparam int IRQ_REFUSED_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;
  // Interval is two to the power of (base + select) oscillator ticks
  localparam int CNT_W = 18;
  localparam int IV_BASE = 10;
  // Reset pulse on overflow
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_PULSE_NS = 64;
  localparam int PULSE_W = 5;
  localparam logic [PULSE_W-1:0] RESET_PULSE_CYC =
    PULSE_W'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// file: common/counter_if.sv
// Carrier between register side and interval counter
`timescale 1ns/100ps
`default_nettype none
interface counter_if;
  logic tick;
  logic enable;
  logic restart;
  logic [supervision_timer_pkg::IV_W-1:0] interval;
  logic [supervision_timer_pkg::CNT_W-1:0] count;
  logic overflow;
  logic half;
  modport ctl (output tick, output enable, output restart, output interval,
               input count, input overflow, input half);
  modport cnt (input tick, input enable, input restart, input interval,
               output count, output overflow, output half);
endinterface
`default_nettype wire

// file: rtl/lfo_tick_sync.sv
// Brings the low-frequency oscillator into sys_clk and marks each rising edge
`timescale 1ns/100ps
`default_nettype none
module lfo_tick_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lfo_clk_in,
  output logic tick
);
  logic meta;
  logic sync;
  logic last;

  // First stage feeds only the second one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta <= 1'h0;
      sync <= 1'h0;
      last <= 1'h0;
    end else begin
      meta <= lfo_clk_in;
      sync <= meta;
      last <= sync;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick <= 1'h0;
    end else begin
      tick <= sync & ~last;
    end
  end
endmodule
`default_nettype wire

// file: rtl/interval_counter.sv
// Interval counter paced by oscillator ticks
`timescale 1ns/100ps
`default_nettype none
module interval_counter (
  input wire logic sys_clk,
  input wire logic rst,
  counter_if.cnt cif
);
  logic [supervision_timer_pkg::CNT_W-1:0] terminal;

  always_comb begin
    terminal = (supervision_timer_pkg::CNT_W'(1) <<
                (supervision_timer_pkg::IV_BASE + int'(cif.interval)))
               - supervision_timer_pkg::CNT_W'(1);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cif.count <= '0;
      cif.overflow <= 1'h0;
      cif.half <= 1'h0;
    end else begin
      cif.overflow <= 1'h0;
      cif.half <= 1'h0;
      if (cif.restart) begin
        // Restart beats a coincident tick
        cif.count <= '0;
      end else if (cif.enable && cif.tick) begin
        if (cif.count >= terminal) begin
          cif.count <= '0;
          cif.overflow <= 1'h1;
        end else begin
          cif.count <= cif.count + supervision_timer_pkg::CNT_W'(1);
          cif.half <= (cif.count == (terminal >> 1));
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/supervision_timer_unit.sv
// Supervision timer with APB registers, interrupt and system reset request
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module supervision_timer_unit (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lfo_clk_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [supervision_timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [supervision_timer_pkg::DATA_W-1:0] pwdata,
  output logic [supervision_timer_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic sys_reset_out,
  output logic rst_pin_out,
  output logic rst_pin_oe_n
);
  counter_if cif ();

  logic lfo_tick;
  logic ctrl_en;
  logic ctrl_lock;
  logic [supervision_timer_pkg::IV_W-1:0] interval;
  logic restart_req;
  logic fired;
  logic [supervision_timer_pkg::PULSE_W-1:0] pulse_cnt;
  logic [supervision_timer_pkg::IRQ_W-1:0] irq_status;
  logic [supervision_timer_pkg::IRQ_W-1:0] irq_mask;
  logic [supervision_timer_pkg::IRQ_W-1:0] irq_set;
  logic refused;
  logic access;
  logic wr_fire;
  logic rd_fire;
  logic wr_ctrl;
  logic addr_ok;
  logic [supervision_timer_pkg::DATA_W-1:0] next_rdata;
  logic [supervision_timer_pkg::IV_W-1:0] wr_iv;

  lfo_tick_sync u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .lfo_clk_in(lfo_clk_in),
    .tick(lfo_tick)
  );

  interval_counter u_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .cif(cif)
  );

  // Counter is paced by the oscillator and frozen after it has fired
  always_comb begin
    cif.tick = lfo_tick;
    cif.enable = ctrl_en & ~fired;
    cif.restart = restart_req;
    cif.interval = interval;
  end

  // APB decode; one wait state gives a registered answer
  always_comb begin
    access = psel & penable;
    wr_fire = access & pready & pwrite;
    rd_fire = access & pready & ~pwrite;
    wr_ctrl = wr_fire && (paddr == supervision_timer_pkg::CTRL_OFFSET);
    wr_iv = pwdata[supervision_timer_pkg::IV_LSB +: supervision_timer_pkg::IV_W];
    addr_ok = (paddr == supervision_timer_pkg::CTRL_OFFSET) ||
              (paddr == supervision_timer_pkg::STATUS_OFFSET) ||
              (paddr == supervision_timer_pkg::IRQ_STATUS_OFFSET) ||
              (paddr == supervision_timer_pkg::IRQ_MASK_OFFSET) ||
              (paddr == supervision_timer_pkg::COUNT_OFFSET);
  end

  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      supervision_timer_pkg::CTRL_OFFSET: begin
        next_rdata[supervision_timer_pkg::EN_BIT] = ctrl_en;
        next_rdata[supervision_timer_pkg::LOCK_BIT] = ctrl_lock;
        next_rdata[supervision_timer_pkg::IV_LSB +: supervision_timer_pkg::IV_W] = interval;
      end
      supervision_timer_pkg::STATUS_OFFSET: begin
        next_rdata[supervision_timer_pkg::ST_EN_BIT] = cif.enable;
        next_rdata[supervision_timer_pkg::ST_LOCK_BIT] = ctrl_lock;
        next_rdata[supervision_timer_pkg::ST_FIRED_BIT] = fired;
      end
      supervision_timer_pkg::IRQ_STATUS_OFFSET: begin
        next_rdata[supervision_timer_pkg::IRQ_W-1:0] = irq_status;
      end
      supervision_timer_pkg::IRQ_MASK_OFFSET: begin
        next_rdata[supervision_timer_pkg::IRQ_W-1:0] = irq_mask;
      end
      supervision_timer_pkg::COUNT_OFFSET: begin
        next_rdata[supervision_timer_pkg::CNT_W-1:0] = cif.count;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'h0;
      pslverr <= 1'h0;
      prdata <= '0;
    end else begin
      pready <= access & ~pready;
      if (access && !pready) begin
        pslverr <= ~addr_ok;
        prdata <= pwrite ? '0 : next_rdata;
      end else begin
        pslverr <= 1'h0;
        prdata <= '0;
      end
    end
  end

  // Configuration; writing the lock bit also sets the timer running
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_en <= supervision_timer_pkg::EN_RESET;
      ctrl_lock <= supervision_timer_pkg::LOCK_RESET;
      interval <= supervision_timer_pkg::IV_MAX;
    end else if (wr_ctrl && !ctrl_lock) begin
      ctrl_en <= pwdata[supervision_timer_pkg::EN_BIT] |
                 pwdata[supervision_timer_pkg::LOCK_BIT];
      ctrl_lock <= pwdata[supervision_timer_pkg::LOCK_BIT];
      interval <= wr_iv;
    end
  end

  // Locked writes leave the settings alone; one whose enable or interval differs from the current setting is reported
  always_comb begin
    refused = wr_ctrl && ctrl_lock &&
              ((pwdata[supervision_timer_pkg::EN_BIT] != ctrl_en) ||
               (wr_iv != interval));
  end

  // Restart is allowed even when locked, it is the keep-alive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      restart_req <= 1'h0;
    end else begin
      restart_req <= wr_ctrl & pwdata[supervision_timer_pkg::RESTART_BIT];
    end
  end

  // Overflow sets fired until the controller resets us and raises the system reset request for a 16-cycle pulse
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fired <= 1'h0;
      pulse_cnt <= '0;
    end else if (cif.overflow) begin
      fired <= 1'h1;
      pulse_cnt <= supervision_timer_pkg::RESET_PULSE_CYC;
    end else if (pulse_cnt != '0) begin
      pulse_cnt <= pulse_cnt - supervision_timer_pkg::PULSE_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_reset_out <= 1'h0;
    end else begin
      sys_reset_out <= cif.overflow || (pulse_cnt > supervision_timer_pkg::PULSE_W'(1));
    end
  end

  // The pad keeps its own reset path; this block never drives it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_pin_out <= 1'h0;
      rst_pin_oe_n <= 1'h1;
    end else begin
      rst_pin_out <= 1'h0;
      rst_pin_oe_n <= 1'h1;
    end
  end

  // Interrupt sources; a new event wins over the read that clears
  always_comb begin
    irq_set = '0;
    irq_set[supervision_timer_pkg::IRQ_HALF_BIT] = cif.half;
    irq_set[supervision_timer_pkg::IRQ_RESTART_BIT] = restart_req;
    irq_set[supervision_timer_pkg::IRQ_REFUSED_BIT] = refused;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_status <= '0;
    end else if (rd_fire && paddr == supervision_timer_pkg::IRQ_STATUS_OFFSET) begin
      irq_status <= irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask <= supervision_timer_pkg::IRQ_MASK_RESET;
    end else if (wr_fire && paddr == supervision_timer_pkg::IRQ_MASK_OFFSET) begin
      irq_mask <= pwdata[supervision_timer_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'h0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_overflow;
    cif.overflow;
  endsequence

  sequence s_reset_hold;
    sys_reset_out [*8];
  endsequence

  sequence s_locked_write;
    ctrl_lock && wr_ctrl;
  endsequence

  property p_overflow_resets;
    s_overflow |=> s_reset_hold;
  endproperty

  property p_lock_freezes;
    s_locked_write |=> ($stable(interval) && ctrl_en && ctrl_lock);
  endproperty

  a_reset_defaults: assert property ($past(rst) |->
    (ctrl_en && !ctrl_lock && interval == supervision_timer_pkg::IV_MAX))
    else $error("timer not enabled at longest interval after reset");

  a_overflow_reset: assert property (p_overflow_resets)
    else $error("overflow did not hold system reset");

  a_reset_cause: assert property ($rose(sys_reset_out) |-> $past(cif.overflow))
    else $error("system reset raised without overflow");

  a_count_paced: assert property ((!lfo_tick && !restart_req) |=> $stable(cif.count))
    else $error("counter moved without an oscillator tick");

  a_lock_sticky: assert property (ctrl_lock |=> (ctrl_lock && ctrl_en))
    else $error("locked timer was released or disabled");

  a_locked_config: assert property (p_lock_freezes)
    else $error("configuration changed while locked");

  a_disable_write: assert property ((wr_ctrl && !ctrl_lock &&
    !pwdata[supervision_timer_pkg::EN_BIT] && !pwdata[supervision_timer_pkg::LOCK_BIT])
    |=> !ctrl_en)
    else $error("unlocked disable write ignored");

  a_pin_untouched: assert property (rst_pin_oe_n && !rst_pin_out)
    else $error("reset pin driven by timer");

  a_restart_clears: assert property (wr_ctrl && pwdata[supervision_timer_pkg::RESTART_BIT]
    |=> ##1 (cif.count == '0))
    else $error("restart did not clear counter");

  a_irq_level: assert property (irq == $past(|(irq_status & irq_mask)))
    else $error("interrupt output disagrees with masked status");

  // Further checks on the bus answer, the fired state and the event flags
  sequence s_restart_pending;
    restart_req;
  endsequence

  sequence s_refused_write;
    refused;
  endsequence

  sequence s_open_write;
    wr_ctrl && !ctrl_lock;
  endsequence

  property p_restart_flagged;
    s_restart_pending |=> irq_status[supervision_timer_pkg::IRQ_RESTART_BIT];
  endproperty

  property p_refusal_flagged;
    s_refused_write |=> irq_status[supervision_timer_pkg::IRQ_REFUSED_BIT];
  endproperty

  property p_open_write_lands;
    s_open_write |=> (interval == $past(wr_iv));
  endproperty

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held for more than one cycle");

  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");

  a_rdata_idle: assert property (!pready |-> (prdata == '0))
    else $error("read data shown outside an answer");

  a_tick_single: assert property (lfo_tick |=> !lfo_tick)
    else $error("oscillator tick longer than one cycle");

  a_fired_sticky: assert property (fired |=> fired)
    else $error("fired state dropped without reset");

  a_fired_frozen: assert property (fired |=> $stable(cif.count))
    else $error("counter moved after overflow");

  a_reset_fired: assert property (sys_reset_out |-> fired)
    else $error("system reset without fired state");

  a_locked_running: assert property (ctrl_lock |-> (cif.enable || fired))
    else $error("locked timer not counting");

  a_open_interval: assert property (p_open_write_lands)
    else $error("unlocked interval write not taken");

  a_refusal_flag: assert property (p_refusal_flagged)
    else $error("refused write not flagged");

  a_restart_flag: assert property (p_restart_flagged)
    else $error("restart not flagged");

  a_half_pulse: assert property (cif.half |=> !cif.half)
    else $error("half interval event longer than one cycle");
endmodule
`default_nettype wire

// file: tb/supervision_timer_unit_tb_top.sv
// Self-checking bench for the supervision timer unit
`timescale 1ns/100ps
`default_nettype none
module supervision_timer_unit_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic lfo_clk_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic sys_reset_out;
  logic rst_pin_out;
  logic rst_pin_oe_n;
  logic [31:0] rdat;
  logic rerr;
  logic watch = 1'b0;
  int num_errors = 0;
  int checks = 0;
  int seed = 32'h34270568;
  int m_en, m_lock, m_iv, m_irq, m_mask, m_cnt, m_fired, n;

  always #2 sys_clk = ~sys_clk;

  supervision_timer_unit supervision_timer_unit_i (.sys_clk(sys_clk), .rst(rst), .lfo_clk_in(lfo_clk_in),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sys_reset_out(sys_reset_out),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n));

  task automatic finish_test();
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fail(input string s);
    num_errors++;
    $display("MISMATCH at %0t: %s", $time, s);
    finish_test();
  endtask

  // Pin stays released even across a timer-caused reset
  always @(posedge sys_clk) if (watch) chk({30'h0, rst_pin_out, rst_pin_oe_n}, 32'h1);

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) fail("no pready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
    chk({31'h0, rerr}, {31'h0, ee});
  endtask

  function automatic logic [31:0] ctrl_v();
    return 32'((m_iv << 4) | (m_lock << 1) | m_en);
  endfunction

  function automatic logic [31:0] status_v();
    return 32'((m_en & !m_fired) | (m_lock << 1) | (m_fired << 2));
  endfunction

  // Model of a control write: a locked unit refuses changes but still restarts
  task automatic wctrl(input logic [31:0] d);
    if (m_lock != 0) begin
      if (d[0] != 1'b1 || int'(d[6:4]) != m_iv) m_irq |= 4;
    end else begin
      m_en = d[0] | d[1];
      m_lock = d[1];
      m_iv = d[6:4];
    end
    if (d[2]) begin
      m_cnt = 0;
      m_irq |= 2;
    end
    apb(1'b1, supervision_timer_pkg::CTRL_OFFSET, d);
  endtask

  task automatic wmask(input int v);
    m_mask = v;
    apb(1'b1, supervision_timer_pkg::IRQ_MASK_OFFSET, 32'(v));
  endtask

  // Apart from the forced overflow edge, the oscillator only runs inside these bursts, so the count is exact afterwards
  task automatic ticks(input int k);
    repeat (k) begin
      @(posedge sys_clk);
      lfo_clk_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      lfo_clk_in <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (8) @(posedge sys_clk);
    if (m_en != 0 && m_fired == 0) m_cnt += k;
    if (m_cnt >= (1 << (9 + m_iv))) m_irq |= 1;
  endtask

  task automatic chk_irq();
    repeat (4) @(posedge sys_clk);
    chk({31'h0, irq}, 32'((m_irq & m_mask) != 0));
  endtask

  task automatic rd_irq();
    rd(supervision_timer_pkg::IRQ_STATUS_OFFSET, 32'(m_irq), 1'b0);
    m_irq = 0;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    m_en = 1;
    m_lock = 0;
    m_iv = 7;
    m_irq = 0;
    m_mask = 0;
    m_cnt = 0;
    m_fired = 0;
  endtask

  initial begin
    do_reset();
    watch <= 1'b1;
    rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    rd(supervision_timer_pkg::STATUS_OFFSET, status_v(), 1'b0);
    rd(supervision_timer_pkg::IRQ_MASK_OFFSET, 32'h0, 1'b0);
    apb(1'b1, 12'h020, $random(seed));
    chk({31'h0, rerr}, 32'h1);
    rd(12'h020, 32'h0, 1'b1);
    rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    for (n = 0; n < 8; n++) begin
      wctrl(32'((n << 4) | 1));
      rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    end
    wmask(2);
    wctrl(32'h5);
    chk_irq();
    rd(supervision_timer_pkg::COUNT_OFFSET, 32'(m_cnt), 1'b0);
    ticks(5);
    rd(supervision_timer_pkg::COUNT_OFFSET, 32'(m_cnt), 1'b0);
    repeat (20) @(posedge sys_clk);
    rd(supervision_timer_pkg::COUNT_OFFSET, 32'(m_cnt), 1'b0);
    rd_irq();
    chk_irq();
    wctrl(32'h0);
    ticks(5);
    rd(supervision_timer_pkg::COUNT_OFFSET, 32'(m_cnt), 1'b0);
    rd(supervision_timer_pkg::STATUS_OFFSET, status_v(), 1'b0);
    wmask(0);
    wctrl(32'h5);
    chk_irq();
    wmask(7);
    chk_irq();
    rd_irq();
    chk_irq();
    // One tick short of the timeout must leave the system running
    ticks(1023);
    rd(supervision_timer_pkg::COUNT_OFFSET, 32'(m_cnt), 1'b0);
    chk({31'h0, sys_reset_out}, 32'h0);
    rd_irq();
    @(posedge sys_clk);
    lfo_clk_in <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk);
      if (sys_reset_out === 1'b1) break;
    end
    if (n == 40) fail("no system reset");
    n = 0;
    while (sys_reset_out === 1'b1 && n < 40) begin
      n++;
      @(posedge sys_clk);
    end
    chk(32'(n), 32'd16);
    lfo_clk_in <= 1'b0;
    m_fired = 1;
    rd(supervision_timer_pkg::STATUS_OFFSET, status_v(), 1'b0);
    do_reset();
    rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    wctrl(32'h2);
    rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    wmask(4);
    wctrl((32'($random(seed)) & 32'h70) | 32'h2);
    rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    chk_irq();
    rd_irq();
    wctrl(32'h13);
    rd(supervision_timer_pkg::CTRL_OFFSET, ctrl_v(), 1'b0);
    chk_irq();
    rd_irq();
    ticks(3);
    wctrl(32'h7);
    rd(supervision_timer_pkg::COUNT_OFFSET, 32'(m_cnt), 1'b0);
    do_reset();
    rd(supervision_timer_pkg::STATUS_OFFSET, status_v(), 1'b0);
    wctrl(32'h0);
    rd(supervision_timer_pkg::STATUS_OFFSET, status_v(), 1'b0);
    finish_test();
  end
endmodule
`default_nettype wire
